// ===== hdl/mirl_env_flags.sv
/*
 * Hysteresis flags for the environmental detectors.
 * Assumes set and clear conditions are synchronised levels.
 */
`timescale 1ns/1ns
module mirl_env_flags #(
    parameter int N = mirl_pkg::NUM_ENV  // Number of flags.
) (
    input  wire logic         clock_i,   // System clock.
    input  wire logic         rst_i,     // Asynchronous reset, high.
    input  wire logic         clk_en_i,  // Clock enable.
    input  wire logic [N-1:0] set_i,     // Trip condition reached.
    input  wire logic [N-1:0] clear_i,   // Release condition reached.
    output logic      [N-1:0] flag_o     // Held flags.
);
    // A flag holds between the two trip points; set wins.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            flag_o <= mirl_pkg::ENV_RST;
        end else if (clk_en_i) begin
            flag_o <= (flag_o & ~clear_i) | set_i;  // RULE_14 RULE_15 RULE_16
        end
    end
endmodule // mirl_env_flags

// ===== hdl/mirl_ext_detect.sv
/*
 * External pin edge and level detector with a one-deep event latch.
 * Assumes the pin level has already been synchronised.
 */
`timescale 1ns/1ns
module mirl_ext_detect (
    input wire logic clock_i,   // System clock.
    input wire logic rst_i,     // Asynchronous reset, high.
    input wire logic clk_en_i,  // Clock enable.
    mirl_ext_if.det  ext        // Detector side of the carrier.
);
    logic prev_level;
    logic latch;
    wire  fall      = prev_level & ~ext.pin_level;
    wire  rise      = ~prev_level & ext.pin_level;
    wire  low_level = (ext.sense_sel == mirl_pkg::SENSE_FALL_LOW)
                      & ~ext.pin_level;

    // Edge selection per sensitivity mode.
    assign ext.event_hit =
        (ext.sense_sel == mirl_pkg::SENSE_RISE) ? rise :  // RULE_03
        (ext.sense_sel == mirl_pkg::SENSE_BOTH) ? (rise | fall) : fall;
    assign ext.pending = latch;
    // Level term bypasses the latch so it is never stored.
    assign ext.request = ext.enable & (latch | low_level);  // RULE_21

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            prev_level <= 1'h1;
            latch      <= 1'h0;
        end else if (clk_en_i) begin
            prev_level <= ext.pin_level;
            if (ext.event_hit) begin
                latch <= 1'h1;  // RULE_08
            end else if (ext.clear) begin
                latch <= 1'h0;  // RULE_09
            end
        end
    end
endmodule // mirl_ext_detect

// ===== hdl/mirl_ext_if.sv
/*
 * Carrier between the request logic and its pin detector.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface mirl_ext_if;
    logic       pin_level;  // Synchronised pin level.
    logic [1:0] sense_sel;  // Selected sensitivity mode.
    logic       enable;     // External interrupt enable.
    logic       clear;      // Discard the latched event.
    logic       event_hit;  // Selected edge seen this cycle.
    logic       pending;    // Latched edge event.
    logic       request;    // Request toward the arbiter.
    modport ctrl (output pin_level, sense_sel, enable, clear,
                  input event_hit, pending, request);
    modport det  (input pin_level, sense_sel, enable, clear,
                  output event_hit, pending, request);
endinterface // mirl_ext_if

// ===== hdl/mirl_pkg.sv
/*
 * Shared constants, types and helpers for the interrupt request logic.
 * Assumes an 8-bit register port and a 16-bit vector address space.
 */
package mirl_pkg;
    // ------------------------------------------------------------------
    // Widths and source counts
    // ------------------------------------------------------------------
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 8;
    localparam int VEC_W     = 16;
    localparam int NUM_ENV   = 3;
    localparam int NUM_WTIM  = 5;
    localparam int NUM_SHORT = 2;
    localparam int NUM_SYNC  = 7;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_SYSTEM_CONTROL     = 8'h0A;
    localparam logic [ADDR_W-1:0] OFS_EXCEPTION_STATUS   = 8'h29;
    localparam logic [ADDR_W-1:0] OFS_EXCEPTION_CONTROL  = 8'h2A;
    localparam logic [ADDR_W-1:0] OFS_CORE_TIMER_CONTROL = 8'h2B;
    localparam logic [ADDR_W-1:0] OFS_SOURCE_STATUS      = 8'h2C;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int SC_SENSE_HI_BIT = 7;
    localparam int SC_SENSE_LO_BIT = 6;
    localparam int SC_ENABLE_BIT   = 5;
    localparam int ES_RESTORED_BIT = 7;
    localparam int ES_PORTC4_BIT   = 6;
    localparam int CT_OVF_BIT      = 1;
    localparam int CT_PER_BIT      = 0;
    localparam logic [1:0]          SENSE_RST  = 2'h0;
    localparam logic                EXT_EN_RST = 1'h1;
    localparam logic [NUM_ENV-1:0]  ENV_RST    = 3'h0;
    localparam logic [1:0]          CT_EN_RST  = 2'h0;
    localparam logic [NUM_SYNC-1:0] SYNC_RST   = 7'h40;

    // ------------------------------------------------------------------
    // Pin sensitivity modes and vectors
    // ------------------------------------------------------------------
    localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
    localparam logic [1:0] SENSE_FALL     = 2'h1;
    localparam logic [1:0] SENSE_RISE     = 2'h2;
    localparam logic [1:0] SENSE_BOTH     = 2'h3;
    localparam logic [VEC_W-1:0] VEC_EXT   = 16'h3FFA;
    localparam logic [VEC_W-1:0] VEC_CTIM  = 16'h3FF8;
    localparam logic [VEC_W-1:0] VEC_WTIM  = 16'h3FF6;
    localparam logic [VEC_W-1:0] VEC_ENV   = 16'h3FF4;
    localparam logic [VEC_W-1:0] VEC_NONE  = 16'h0000;

    typedef enum logic [1:0] {ST_IDLE, ST_STACK, ST_VECTOR} mirl_state_e;

    // Highest vector address wins among the pending requests.
    function automatic logic [VEC_W-1:0] mirl_pick_vector(
        input logic ext, input logic ctim, input logic wtim,
        input logic env);
        return ext  ? VEC_EXT  :
               ctim ? VEC_CTIM :
               wtim ? VEC_WTIM :
               env  ? VEC_ENV  : VEC_NONE;
    endfunction
endpackage

// ===== hdl/mirl_top.sv
/*
 * Interrupt request logic: pin detector control, source gathering,
 * recognition, stacking handshake and vector selection.
 * Assumes the core sets its global mask on mask_set_o in the same edge,
 * and that timer and port flags come from logic on this clock.
 */
// Our own choice: the address-and-strobe port.
// Operation
// [RULE_01] Pin recognised: mask clear, enabled, sensed.
// [RULE_02] Recognition stacks, sets mask, fetches 3FFA vector.
// [RULE_03] Select bits pick one of four sensitivities.
// [RULE_04] Select bits writable only masked; reset zero.
// [RULE_05] Enable writable only masked; reset set.
// [RULE_06] Option writes ignored while mask clear.
// [RULE_07] Changing sensitivity discards pending pin request.
// [RULE_08] Edge latched while disabled, pending until enabled.
// [RULE_09] Latch cleared at service; level never latched.
// [RULE_10] Timer wrap with enable requests core timer.
// [RULE_11] Periodic tick with enable requests core timer.
// [RULE_12] Any enabled wide timer flag requests 3FF6.
// [RULE_13] Any enabled environmental flag requests 3FF4.
// [RULE_14] Overtemperature flag has set/clear hysteresis.
// [RULE_15] Overvoltage flag has set/clear hysteresis.
// [RULE_16] Undervoltage flag has set/clear hysteresis.
// [RULE_17] Software disables and polls before re-enabling.
// [RULE_18] Enabled port C short flags request 3FF4.
// [RULE_19] Highest pending vector address serviced first.
// [RULE_20] Global mask blocks all hardware requests.
// [RULE_21] Low-level mode requests while pin stays low.
// [RULE_22] Each vector ORs flags ANDed with enables.
`timescale 1ns/1ns
module mirl_top (
    input  wire logic                        clock_i,     // 25 MHz clock.
    input  wire logic                        rst_i,       // Async reset.
    input  wire logic                        clk_en_i,    // Clock enable.
    input  wire logic [mirl_pkg::ADDR_W-1:0] reg_addr_i,  // Reg address.
    input  wire logic [mirl_pkg::DATA_W-1:0] reg_wdata_i, // Write data.
    input  wire logic                        reg_wr_i,    // Write strobe.
    input  wire logic                        reg_rd_i,    // Read strobe.
    output logic      [mirl_pkg::DATA_W-1:0] reg_rdata_o, // Read data.
    input  wire logic                        global_mask_i, // Core I bit.
    input  wire logic                        irq_pin_n_i, // External pin.
    input  wire logic                        ot_above_hi_i, // Temp high.
    input  wire logic                        ot_below_lo_i, // Temp low.
    input  wire logic                        ov_above_hi_i, // Supply high.
    input  wire logic                        ov_below_lo_i, // Supply ok.
    input  wire logic                        uv_below_lo_i, // Supply low.
    input  wire logic                        uv_above_hi_i, // Supply ok.
    input  wire logic                        tick_overflow_flag_i, // Wrap.
    input  wire logic                        periodic_flag_i, // Tick.
    input  wire logic [mirl_pkg::NUM_WTIM-1:0] wide_timer_status_i, // Fl.
    input  wire logic [mirl_pkg::NUM_WTIM-1:0] wide_timer_control_i, // En.
    input  wire logic [mirl_pkg::NUM_SHORT-1:0] portc_short_flag_i, // Fl.
    input  wire logic [mirl_pkg::NUM_SHORT-1:0] portc_short_enable_i, // En.
    input  wire logic                        clock_restored_status_i, // St.
    input  wire logic                        portc4_current_limit_i, // St.
    input  wire logic                        stack_done_i, // Stack done.
    output logic                             stack_push_o, // Stack now.
    output logic                             mask_set_o,   // Set I bit.
    output logic                             vector_valid_o, // Fetch.
    output logic      [mirl_pkg::VEC_W-1:0]  vector_addr_o, // Vector high.
    output logic                             request_o     // Any request.
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [mirl_pkg::NUM_SYNC-1:0] sync_meta;
    logic [mirl_pkg::NUM_SYNC-1:0] sync_out;
    logic [1:0]                    sense_sel;
    logic                          ext_int_enable;
    logic [mirl_pkg::NUM_ENV-1:0]  env_enable;
    logic                          tick_overflow_enable;
    logic                          periodic_int_enable;
    logic [mirl_pkg::NUM_ENV-1:0]  env_flag;
    logic [mirl_pkg::VEC_W-1:0]    captured_vec;
    mirl_pkg::mirl_state_e         state;
    mirl_pkg::mirl_state_e         next_state;
    mirl_ext_if                    ext_if ();

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Asynchronous pin and comparators pass two flip-flops.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sync_meta <= mirl_pkg::SYNC_RST;
            sync_out  <= mirl_pkg::SYNC_RST;
        end else if (clk_en_i) begin
            sync_meta <= {irq_pin_n_i, ot_above_hi_i, ot_below_lo_i,
                          ov_above_hi_i, ov_below_lo_i, uv_below_lo_i,
                          uv_above_hi_i};
            sync_out  <= sync_meta;
        end
    end

    // Named views of the synchronised levels.
    wire pin_level = sync_out[6];
    wire ot_set    = sync_out[5];
    wire ot_clr    = sync_out[4];
    wire ov_set    = sync_out[3];
    wire ov_clr    = sync_out[2];
    wire uv_set    = sync_out[1];
    wire uv_clr    = sync_out[0];

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    // Address hits and write qualification.
    wire hit_sc  = reg_addr_i == mirl_pkg::OFS_SYSTEM_CONTROL;
    wire hit_es  = reg_addr_i == mirl_pkg::OFS_EXCEPTION_STATUS;
    wire hit_ec  = reg_addr_i == mirl_pkg::OFS_EXCEPTION_CONTROL;
    wire hit_ct  = reg_addr_i == mirl_pkg::OFS_CORE_TIMER_CONTROL;
    wire hit_ss  = reg_addr_i == mirl_pkg::OFS_SOURCE_STATUS;
    wire sc_take = reg_wr_i & hit_sc & global_mask_i;  // RULE_04 RULE_05 RULE_06
    wire [1:0] wr_sense = {reg_wdata_i[mirl_pkg::SC_SENSE_HI_BIT],
                           reg_wdata_i[mirl_pkg::SC_SENSE_LO_BIT]};
    wire sense_change = sc_take & (wr_sense != sense_sel);  // RULE_07

    // Control registers written by software.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sense_sel            <= mirl_pkg::SENSE_RST;   // RULE_04
            ext_int_enable       <= mirl_pkg::EXT_EN_RST;  // RULE_05
            env_enable           <= mirl_pkg::ENV_RST;
            tick_overflow_enable <= mirl_pkg::CT_EN_RST[mirl_pkg::CT_OVF_BIT];
            periodic_int_enable  <= mirl_pkg::CT_EN_RST[mirl_pkg::CT_PER_BIT];
        end else if (clk_en_i) begin
            if (sc_take) begin
                sense_sel      <= wr_sense;
                ext_int_enable <= reg_wdata_i[mirl_pkg::SC_ENABLE_BIT];
            end
            if (reg_wr_i & hit_ec) begin
                env_enable <= reg_wdata_i[mirl_pkg::NUM_ENV-1:0];
            end
            if (reg_wr_i & hit_ct) begin
                tick_overflow_enable <= reg_wdata_i[mirl_pkg::CT_OVF_BIT];
                periodic_int_enable  <= reg_wdata_i[mirl_pkg::CT_PER_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin detector and environmental flags
    // ------------------------------------------------------------------
    wire servicing_ext = (state == mirl_pkg::ST_VECTOR)
                         & (vector_addr_o == mirl_pkg::VEC_EXT);
    assign ext_if.pin_level = pin_level;
    assign ext_if.sense_sel = sense_sel;
    assign ext_if.enable    = ext_int_enable;
    assign ext_if.clear     = sense_change | servicing_ext;  // RULE_07 RULE_09

    mirl_ext_detect u_ext (
        .clock_i  (clock_i),
        .rst_i    (rst_i),
        .clk_en_i (clk_en_i),
        .ext      (ext_if.det)
    );

    // Flag order is overtemperature, overvoltage, undervoltage.
    mirl_env_flags #(.N(mirl_pkg::NUM_ENV)) u_env (
        .clock_i  (clock_i),
        .rst_i    (rst_i),
        .clk_en_i (clk_en_i),
        .set_i    ({ot_set, ov_set, uv_set}),  // RULE_14 RULE_15 RULE_16
        .clear_i  ({ot_clr, ov_clr, uv_clr}),
        .flag_o   (env_flag)
    );

    // ------------------------------------------------------------------
    // Request gathering
    // ------------------------------------------------------------------
    // Each shared vector ORs its flags gated by their enables.
    wire ext_req  = ext_if.request;  // RULE_01
    wire ctim_req = (tick_overflow_flag_i & tick_overflow_enable)  // RULE_10
                  | (periodic_flag_i & periodic_int_enable);  // RULE_11 RULE_22
    wire wtim_req = |(wide_timer_status_i & wide_timer_control_i);  // RULE_12
    wire env_req  = |(env_flag & env_enable)  // RULE_13
                  | |(portc_short_flag_i & portc_short_enable_i);  // RULE_18
    wire any_req  = ext_req | ctim_req | wtim_req | env_req;
    wire [mirl_pkg::VEC_W-1:0] best_vec =
        mirl_pkg::mirl_pick_vector(ext_req, ctim_req, wtim_req, env_req);
    assign request_o = any_req;

    // ------------------------------------------------------------------
    // Recognition and vectoring
    // ------------------------------------------------------------------
    // Recognition only while the global mask is clear.
    always_comb begin
        next_state = state;
        case (state)
            mirl_pkg::ST_IDLE: begin
                if (any_req & ~global_mask_i) begin
                    next_state = mirl_pkg::ST_STACK;  // RULE_01 RULE_20
                end
            end
            mirl_pkg::ST_STACK: begin
                if (stack_done_i) begin
                    next_state = mirl_pkg::ST_VECTOR;  // RULE_02
                end
            end
            mirl_pkg::ST_VECTOR: begin
                next_state = mirl_pkg::ST_IDLE;
            end
            default: begin
                next_state = mirl_pkg::ST_IDLE;
            end
        endcase
    end

    // State, captured entry vector and chosen vector.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state         <= mirl_pkg::ST_IDLE;
            captured_vec  <= mirl_pkg::VEC_NONE;
            vector_addr_o <= mirl_pkg::VEC_NONE;
        end else if (clk_en_i) begin
            state <= next_state;
            if (state == mirl_pkg::ST_IDLE) begin
                captured_vec <= best_vec;
            end
            if ((state == mirl_pkg::ST_STACK) & stack_done_i) begin
                // Re-arbitrate after stacking; keep entry vector if gone.
                vector_addr_o <= any_req ? best_vec : captured_vec;  // RULE_19
            end
        end
    end

    assign stack_push_o   = state == mirl_pkg::ST_STACK;  // RULE_02
    assign vector_valid_o = state == mirl_pkg::ST_VECTOR;
    assign mask_set_o     = state == mirl_pkg::ST_VECTOR;  // RULE_02

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // Read multiplexer; unmapped addresses read zero.
    wire [mirl_pkg::DATA_W-1:0] sc_val = {sense_sel, ext_int_enable, 5'h00};
    wire [mirl_pkg::DATA_W-1:0] es_val = {clock_restored_status_i,
                                          portc4_current_limit_i, 3'h0,
                                          env_flag};
    wire [mirl_pkg::DATA_W-1:0] ec_val = {5'h00, env_enable};
    wire [mirl_pkg::DATA_W-1:0] ct_val = {6'h00, tick_overflow_enable,
                                          periodic_int_enable};
    wire [mirl_pkg::DATA_W-1:0] ss_val = {4'h0, ext_if.pending, ctim_req,
                                          wtim_req, env_req};
    wire [mirl_pkg::DATA_W-1:0] rd_mux = hit_sc ? sc_val :
                                         hit_es ? es_val :
                                         hit_ec ? ec_val :
                                         hit_ct ? ct_val :
                                         hit_ss ? ss_val : 8'h00;

    // Read data stand for exactly the cycle after the strobe.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (clk_en_i) begin
            reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i || !clk_en_i);

    chk_mask_blocks: assert property ( // RULE_20
        $rose(stack_push_o) |-> $past(!global_mask_i))
        else $error("Stacking began while the mask was set.");
    chk_stack_vector: assert property ( // RULE_02
        stack_push_o && stack_done_i |=> vector_valid_o && mask_set_o
        ##1 !vector_valid_o)
        else $error("Vector fetch did not follow stacking.");
    chk_ext_first: assert property ( // RULE_19
        stack_push_o && stack_done_i && ext_req
        |=> vector_addr_o == mirl_pkg::VEC_EXT)
        else $error("Pin request lost priority.");
    chk_option_lock: assert property ( // RULE_06
        reg_wr_i && hit_sc && !global_mask_i
        |=> $stable(sense_sel) && $stable(ext_int_enable))
        else $error("Options changed while mask clear.");
    chk_option_write: assert property ( // RULE_04
        sc_take |=> sense_sel == $past(wr_sense))
        else $error("Masked option write not taken.");
    chk_sense_discard: assert property ( // RULE_07
        sense_change && !ext_if.event_hit |=> !ext_if.pending)
        else $error("Pending request survived a mode change.");
    chk_level_hold: assert property ( // RULE_21
        ext_int_enable && sense_sel == mirl_pkg::SENSE_FALL_LOW
        && !pin_level |-> request_o)
        else $error("Low level did not request.");
    chk_wide_req: assert property ( // RULE_12
        |(wide_timer_status_i & wide_timer_control_i) |-> request_o)
        else $error("Wide timer request missing.");
    chk_temp_hold: assert property ( // RULE_14
        env_flag[2] && !ot_clr && !ot_set |=> env_flag[2])
        else $error("Overtemperature flag dropped early.");
    chk_read_once: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("Read data outside the answer cycle.");

    cov_ext_service: cover property (vector_valid_o
        && vector_addr_o == mirl_pkg::VEC_EXT);
    cov_env_service: cover property (vector_valid_o
        && vector_addr_o == mirl_pkg::VEC_ENV);
    cov_mode_change: cover property (sense_change && ext_if.pending);
    cov_both_edges: cover property (sense_sel == mirl_pkg::SENSE_BOTH
        && ext_if.event_hit);
endmodule // mirl_top

// ===== verification/mirl_core_model.sv
/* Core model: stacking handshake and global mask bit.
   Assumes the request logic's clock and reset. */
`timescale 1ns/1ns
module mirl_core_model (
    input  wire logic clock_i,   // System clock.
    input  wire logic rst_i,     // Async reset, high.
    input  wire logic push_i,    // Stacking requested.
    input  wire logic mset_i,    // Set the mask.
    input  wire logic mclr_i,    // Software clears the mask.
    input  wire logic slow_i,    // Stack slowly.
    output logic      done_o,    // Stacking finished.
    output logic      mask_o     // Global mask.
);
    logic [1:0] cnt;
    // Mask starts set, is set at vector fetch, cleared by software.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            mask_o <= 1'h1;
            cnt <= 2'h0;
            done_o <= 1'h0;
        end else begin
            mask_o <= mset_i | (mask_o & ~mclr_i);
            cnt <= push_i ? cnt + 2'h1 : 2'h0;
            done_o <= push_i & ~done_o & (!slow_i | cnt == 2'h3);
        end
    end
endmodule // mirl_core_model

// ===== verification/mirl_top_tb.sv
/* Bench for the interrupt request logic.
   Assumes the core model beside it. */
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
 $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module mirl_top_tb;
    logic clk = 0, rst = 1, wr = 0, rd = 0, pin = 1, clr = 0, slow = 0;
    logic sset = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
    logic [23:0] src = 24'h000000;
    logic push, mset, vv, req, done, mask;
    logic [15:0] vec;
    int err_total = 0, cmp_count = 0;
    always #20 clk = ~clk;
    mirl_core_model core (.clock_i(clk), .rst_i(rst), .push_i(push),
        .mset_i(mset | sset), .mclr_i(clr), .slow_i(slow), .done_o(done),
        .mask_o(mask));
    mirl_top uut (.clock_i(clk), .rst_i(rst), .clk_en_i(1'h1),
        .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .global_mask_i(mask), .irq_pin_n_i(pin),
        .ot_above_hi_i(src[0]), .ot_below_lo_i(src[1]),
        .ov_above_hi_i(src[2]), .ov_below_lo_i(src[3]),
        .uv_below_lo_i(src[4]), .uv_above_hi_i(src[5]),
        .tick_overflow_flag_i(src[6]), .periodic_flag_i(src[7]),
        .wide_timer_status_i(src[12:8]), .wide_timer_control_i(src[17:13]),
        .portc_short_flag_i(src[19:18]), .portc_short_enable_i(src[21:20]),
        .clock_restored_status_i(src[22]), .portc4_current_limit_i(src[23]),
        .stack_done_i(done), .stack_push_o(push), .mask_set_o(mset),
        .vector_valid_o(vv), .vector_addr_o(vec), .request_o(req));
    task automatic wrap_up();
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) begin addr <= a; wd <= d; wr <= 1'h1; end
        @(posedge clk) wr <= 1'h0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) begin addr <= a; rd <= 1'h1; end
        @(posedge clk) rd <= 1'h0;
        @(negedge clk) d = rdata;
    endtask
    // Clears the mask and waits for the vector fetch.
    task automatic svc(input logic [15:0] exp_vec);
        int n;
        @(posedge clk) clr <= 1'h1;
        @(posedge clk) clr <= 1'h0;
        for (n = 0; n < 20 && vv !== 1'h1; n++) @(negedge clk);
        if (n == 20) begin err_total++; wrap_up(); end
        `CHK(vec, exp_vec)
        `CHK(mset, 1'h1)
    endtask
    task automatic t_options();
        logic [7:0] d;
        rreg(8'h0A, d); `CHK(d, 8'h20)
        wreg(8'h0A, 8'h40);
        rreg(8'h0A, d); `CHK(d, 8'h40)
        @(posedge clk) clr <= 1'h1;
        @(posedge clk) clr <= 1'h0;
        wreg(8'h0A, 8'hE0);
        rreg(8'h0A, d); `CHK(d, 8'h40)
        rreg(8'h55, d); `CHK(d, 8'h00)
    endtask
    task automatic t_pin();
        logic [7:0] d;
        @(posedge clk) pin <= 1'h0;
        repeat (4) @(posedge clk);
        rreg(8'h2C, d); `CHK(d, 8'h08)
        `CHK(req, 1'h0)
        @(posedge clk) sset <= 1'h1;
        @(posedge clk) sset <= 1'h0;
        wreg(8'h0A, 8'h60);
        @(negedge clk); `CHK(req, 1'h1)
        svc(16'h3FFA);
        rreg(8'h2C, d); `CHK(d, 8'h00)
    endtask
    task automatic t_env();
        logic [7:0] d;
        int n;
        @(posedge clk) begin slow <= 1'h1; src <= 24'h000041; end
        wreg(8'h2A, 8'h04);
        wreg(8'h2B, 8'h02);
        svc(16'h3FF8);
        @(posedge clk) src <= 24'h000000;
        svc(16'h3FF4);
        wreg(8'h2A, 8'h00);
        rreg(8'h29, d); `CHK(d, 8'h04)
        @(posedge clk) src <= 24'h000002;
        for (n = 0; n < 8 && d !== 8'h00; n++) rreg(8'h29, d);
        `CHK(d, 8'h00)
        wreg(8'h2A, 8'h04);
        @(negedge clk); `CHK(req, 1'h0)
    endtask
    // Walks the rise, both-edge and level modes of the pin.
    task automatic t_modes();
        wreg(8'h0A, 8'hA0);
        repeat (4) @(posedge clk);
        @(negedge clk); `CHK(req, 1'h0)
        @(posedge clk) pin <= 1'h1;
        repeat (4) @(posedge clk);
        @(negedge clk); `CHK(req, 1'h1)
        wreg(8'h0A, 8'hE0);
        @(negedge clk); `CHK(req, 1'h0)
        @(posedge clk) pin <= 1'h0;
        repeat (4) @(posedge clk);
        @(negedge clk); `CHK(req, 1'h1)
        svc(16'h3FFA);
        wreg(8'h0A, 8'h20);
        @(negedge clk); `CHK(req, 1'h1)
        @(posedge clk) pin <= 1'h1;
        repeat (4) @(posedge clk);
        @(negedge clk); `CHK(req, 1'h0)
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        t_options();
        t_pin();
        t_env();
        t_modes();
        wrap_up();
    end
endmodule // mirl_top_tb
